// ### dual_fifo_reset_and_offset_defines.svh
// constants for the dual queue reset and flag offset block
`ifndef DUAL_FIFO_RESET_AND_OFFSET_DEFINES_SVH
`define DUAL_FIFO_RESET_AND_OFFSET_DEFINES_SVH

// queue geometry and reset sequencing
`define QUEUE_DEPTH        7'h40
`define PTR_RESET          7'h00
`define RESET_EDGE_COUNT   3'h4
`define EDGE_COUNT_RESET   3'h0

// offset select encodings and values
`define OFFSET_SEL_RESET   2'h0
`define OFFSET_RESET       7'h04
`define OFFSET_VAL_16      7'h10
`define OFFSET_VAL_12      7'h0C
`define OFFSET_VAL_8       7'h08
`define OFFSET_VAL_4       7'h04

// register byte addresses
`define REG_CONTROL        4'h0
`define REG_STATUS         4'h4
`define REG_MASK           4'h8
`define REG_STATE          4'hC

// control fields and reset values
`define CTRL_PORTS_ENABLE  0
`define CONTROL_RESET      1'h1
`define MASK_RESET         4'h0
`define STATUS_RESET       4'h0

// status and mask bit positions
`define EV_RESET_TAKEN     0
`define EV_OFFSET_LATCHED  1
`define EV_WRITE_REFUSED   2
`define EV_READ_REFUSED    3

// state word fields
`define ST_OFFSET_LSB      0
`define ST_SELECT_LSB      8
`define ST_APPLIED_BIT     12
`define ST_EVER_BIT        13
`define ST_COUNT0_LSB      16
`define ST_COUNT1_LSB      24

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### dual_fifo_reset_and_offset_pkg.sv
// types shared by the dual queue reset and flag offset block
package dual_fifo_reset_and_offset_pkg;

    // release sequence of one full flag after a device reset
    typedef enum logic [1:0] {
        FULL_HELD,
        FULL_WAIT_FIRST,
        FULL_WAIT_SECOND,
        FULL_OPEN
    } fullState_t;

endpackage : dual_fifo_reset_and_offset_pkg

// ### dual_fifo_reset_and_offset.sv
// reset, pointer clearing, flag forcing and offset latch of a two-queue device
//
// Summary of operation
// - reset needs four edges of each port clock
// - reset pin may change at any moment
// - effective reset clears both queue pointers
// - reset forces full, empty, almost flags
// - reset forces both mailbox flags high
// - full flags rise on second port edge
// - reset rising edge latches offset select pins
// - select codes map to 16, 12, 8, 4
// - writes ignored while full flag low
// - reads ignored while empty flag low
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "dual_fifo_reset_and_offset_defines.svh"

module dual_fifo_reset_and_offset (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        portAClock,
    input  wire logic        portBClock,
    input  wire logic        deviceResetN,
    input  wire logic        offsetSelectLo,
    input  wire logic        offsetSelectHi,
    input  wire logic        portAWriteEnable,
    input  wire logic        portAReadEnable,
    input  wire logic        portBWriteEnable,
    input  wire logic        portBReadEnable,
    output logic             portAFullFlagN,
    output logic             portBFullFlagN,
    output logic             portAEmptyFlagN,
    output logic             portBEmptyFlagN,
    output logic             portAAlmostEmptyFlagN,
    output logic             portBAlmostEmptyFlagN,
    output logic             portAAlmostFullFlagN,
    output logic             portBAlmostFullFlagN,
    output logic             mailOneFlagN,
    output logic             mailTwoFlagN,
    output logic             interrupt,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // offset value for a select code, high bit first
    function automatic logic [6:0] offsetFromSelect(input logic [1:0] sel);
        case (sel)
            2'h3:    offsetFromSelect = `OFFSET_VAL_16;
            2'h2:    offsetFromSelect = `OFFSET_VAL_12;
            2'h1:    offsetFromSelect = `OFFSET_VAL_8;
            default: offsetFromSelect = `OFFSET_VAL_4;
        endcase
    endfunction : offsetFromSelect

    // true for the four word addresses of the register file
    function automatic logic isMapped(input logic [3:0] addr);
        isMapped = (addr == `REG_CONTROL) || (addr == `REG_STATUS) ||
                   (addr == `REG_MASK) || (addr == `REG_STATE);
    endfunction : isMapped

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]  portClk;            // index 0 is port A, 1 is port B
    logic [1:0]  clkPrev_q;          // last sampled port clock levels
    logic [1:0]  clkRise;            // one-cycle pulse per sampled rising edge
    logic [1:0]  writeEn;            // write strobe per port
    logic [1:0]  readEn;             // read strobe per port
    logic        resetNPrev_q;       // last sampled reset pin level
    logic        resetRelease;       // pin went high this cycle
    logic [2:0]  edgeCount_q [2];    // port edges seen while pin held low
    logic        countsFull;         // both ports saw enough edges
    logic        effect_q;           // current low pulse already took effect
    logic        takingEffect;       // first cycle a low pulse takes effect
    logic        everReset_q;        // at least one effective reset seen
    logic [1:0]  offsetSel_q;        // latched select code
    logic [6:0]  offsetValue_q;      // latched almost-flag offset
    logic [6:0]  wrPtr_q [2];        // write pointer, index is queue
    logic [6:0]  rdPtr_q [2];        // read pointer, index is queue
    logic [6:0]  queueCount [2];     // words stored per queue
    logic [1:0]  wrAccept;           // write taken into queue
    logic [1:0]  rdAccept;           // read taken from queue
    logic [1:0]  wrRefused;          // write dropped, queue full
    logic [1:0]  rdRefused;          // read dropped, queue empty
    dual_fifo_reset_and_offset_pkg::fullState_t fullState_q [2];
    dual_fifo_reset_and_offset_pkg::fullState_t fullState_d [2];
    logic [1:0]  fullN_q;            // full flag per port, low means full
    logic [1:0]  emptyN_q;           // empty flag per port
    logic [1:0]  almostEmptyN_q;     // almost-empty flag per port
    logic [1:0]  almostFullN_q;      // almost-full flag per port
    logic [1:0]  mailN_q;            // mailbox flags, one then two
    logic        portsEnable_q;      // software gate on port strobes
    logic [3:0]  status_q;           // sticky events
    logic [3:0]  mask_q;             // interrupt enables
    logic [3:0]  eventSet;           // events raised this cycle
    logic        statusReadClear;    // status word read this cycle
    logic        awHeld_q;           // write address captured
    logic [3:0]  awAddr_q;           // captured write address
    logic        wHeld_q;            // write data captured
    logic [31:0] wData_q;            // captured write data
    logic [3:0]  wStrb_q;            // captured byte enables
    logic        doWrite;            // address and data both present
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] stateWord;          // read view of block state

    assign portClk = {portBClock, portAClock};
    assign writeEn = {portBWriteEnable, portAWriteEnable};
    assign readEn  = {portBReadEnable, portAReadEnable};
    assign clkRise = portClk & ~clkPrev_q;
    assign resetRelease = deviceResetN & ~resetNPrev_q;
    assign countsFull = (edgeCount_q[0] == `RESET_EDGE_COUNT) &&
                        (edgeCount_q[1] == `RESET_EDGE_COUNT);
    assign takingEffect = ~deviceResetN & countsFull & ~effect_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling and reset pulse qualification

    // the pin is sampled, never used as a reset, so any alignment is safe
    always_ff @(posedge clock) begin
        if (reset) begin
            clkPrev_q    <= 2'h0;
            resetNPrev_q <= 1'h1;
        end else begin
            clkPrev_q    <= portClk;
            resetNPrev_q <= deviceResetN;
        end
    end

    // remembers whether the current low pulse and any pulse took effect
    always_ff @(posedge clock) begin
        if (reset) begin
            effect_q    <= 1'h0;
            everReset_q <= 1'h0;
        end else begin
            effect_q <= ~deviceResetN & countsFull;
            if (takingEffect) begin
                everReset_q <= 1'h1;
            end
        end
    end

    // offset captured at the pin's rising edge, frozen otherwise
    always_ff @(posedge clock) begin
        if (reset) begin
            offsetSel_q   <= `OFFSET_SEL_RESET;
            offsetValue_q <= `OFFSET_RESET;
        end else if (resetRelease) begin
            offsetSel_q   <= {offsetSelectHi, offsetSelectLo};
            offsetValue_q <= offsetFromSelect({offsetSelectHi, offsetSelectLo});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-port and per-queue logic; queue q is written by port q

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            localparam int OTHER = 1 - p;

            // edge counter saturates; cleared whenever the pin is high
            always_ff @(posedge clock) begin
                if (reset || deviceResetN) begin
                    edgeCount_q[p] <= `EDGE_COUNT_RESET;
                end else if (clkRise[p] && edgeCount_q[p] != `RESET_EDGE_COUNT) begin
                    edgeCount_q[p] <= 3'(edgeCount_q[p] + 3'h1);
                end
            end

            // strobes only count on a port edge while the pin is high
            assign wrAccept[p]  = clkRise[p] & writeEn[p] & fullN_q[p] &
                                  portsEnable_q & deviceResetN;
            assign wrRefused[p] = clkRise[p] & writeEn[p] & ~fullN_q[p] &
                                  portsEnable_q & deviceResetN;
            assign rdAccept[p]  = clkRise[OTHER] & readEn[OTHER] & emptyN_q[OTHER] &
                                  portsEnable_q & deviceResetN;
            assign rdRefused[p] = clkRise[OTHER] & readEn[OTHER] & ~emptyN_q[OTHER] &
                                  portsEnable_q & deviceResetN;
            assign queueCount[p] = 7'(wrPtr_q[p] - rdPtr_q[p]);

            // pointers return home only once the pulse qualifies
            always_ff @(posedge clock) begin
                if (reset || (~deviceResetN && countsFull)) begin
                    wrPtr_q[p] <= `PTR_RESET;
                    rdPtr_q[p] <= `PTR_RESET;
                end else begin
                    if (wrAccept[p]) begin
                        wrPtr_q[p] <= 7'(wrPtr_q[p] + 7'h01);
                    end
                    if (rdAccept[p]) begin
                        rdPtr_q[p] <= 7'(rdPtr_q[p] + 7'h01);
                    end
                end
            end

            // full flag release: two port edges after the pin goes high
            always_comb begin
                fullState_d[p] = fullState_q[p];
                case (fullState_q[p])
                    dual_fifo_reset_and_offset_pkg::FULL_HELD: begin
                        // never opened before the first effective reset
                        if (resetRelease && (everReset_q || countsFull)) begin
                            fullState_d[p] = dual_fifo_reset_and_offset_pkg::FULL_WAIT_FIRST;
                        end
                    end
                    dual_fifo_reset_and_offset_pkg::FULL_WAIT_FIRST: begin
                        if (clkRise[p]) begin
                            fullState_d[p] = dual_fifo_reset_and_offset_pkg::FULL_WAIT_SECOND;
                        end
                    end
                    dual_fifo_reset_and_offset_pkg::FULL_WAIT_SECOND: begin
                        if (clkRise[p]) begin
                            fullState_d[p] = dual_fifo_reset_and_offset_pkg::FULL_OPEN;
                        end
                    end
                    dual_fifo_reset_and_offset_pkg::FULL_OPEN: begin
                        fullState_d[p] = dual_fifo_reset_and_offset_pkg::FULL_OPEN;
                    end
                    default: begin
                        fullState_d[p] = dual_fifo_reset_and_offset_pkg::FULL_HELD;
                    end
                endcase
                if (~deviceResetN) begin
                    fullState_d[p] = dual_fifo_reset_and_offset_pkg::FULL_HELD;
                end
            end

            always_ff @(posedge clock) begin
                if (reset) begin
                    fullState_q[p] <= dual_fifo_reset_and_offset_pkg::FULL_HELD;
                end else begin
                    fullState_q[p] <= fullState_d[p];
                end
            end

            // flags are registered; they lag a pointer move by one cycle, safe
            // because sampled port edges are at least two cycles apart
            always_ff @(posedge clock) begin
                if (reset || ~deviceResetN) begin
                    fullN_q[p]        <= 1'h0;
                    emptyN_q[p]       <= 1'h0;
                    almostEmptyN_q[p] <= 1'h0;
                    almostFullN_q[p]  <= 1'h1;
                end else begin
                    fullN_q[p]  <= (fullState_d[p] == dual_fifo_reset_and_offset_pkg::FULL_OPEN)
                                   && (queueCount[p] != `QUEUE_DEPTH);
                    emptyN_q[p] <= everReset_q && (queueCount[OTHER] != `PTR_RESET);
                    almostEmptyN_q[p] <= queueCount[OTHER] > offsetValue_q;
                    almostFullN_q[p]  <= queueCount[p] < 7'(`QUEUE_DEPTH - offsetValue_q);
                end
            end
        end
    endgenerate

    // mailbox transfers live elsewhere; only the reset state is kept here
    always_ff @(posedge clock) begin
        if (reset || ~deviceResetN) begin
            mailN_q <= 2'h3;
        end
    end

    assign portAFullFlagN        = fullN_q[0];
    assign portBFullFlagN        = fullN_q[1];
    assign portAEmptyFlagN       = emptyN_q[0];
    assign portBEmptyFlagN       = emptyN_q[1];
    assign portAAlmostEmptyFlagN = almostEmptyN_q[0];
    assign portBAlmostEmptyFlagN = almostEmptyN_q[1];
    assign portAAlmostFullFlagN  = almostFullN_q[0];
    assign portBAlmostFullFlagN  = almostFullN_q[1];
    assign mailOneFlagN          = mailN_q[0];
    assign mailTwoFlagN          = mailN_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // status, mask and interrupt

    always_comb begin
        eventSet = `STATUS_RESET;
        eventSet[`EV_RESET_TAKEN]    = takingEffect;
        eventSet[`EV_OFFSET_LATCHED] = resetRelease;
        eventSet[`EV_WRITE_REFUSED]  = |wrRefused;
        eventSet[`EV_READ_REFUSED]   = |rdRefused;
    end

    assign statusReadClear = arvalid & arready & (araddr == `REG_STATUS);

    // a read clears; an event in the same cycle survives
    always_ff @(posedge clock) begin
        if (reset) begin
            status_q <= `STATUS_RESET;
        end else begin
            status_q <= (statusReadClear ? `STATUS_RESET : status_q) | eventSet;
        end
    end

    assign interrupt = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    assign awready = ~awHeld_q & ~bvalid_q;
    assign wready  = ~wHeld_q & ~bvalid_q;
    assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;
    assign arready = ~rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;

    // address and data captured independently, in either order
    always_ff @(posedge clock) begin
        if (reset) begin
            awHeld_q <= 1'h0;
            awAddr_q <= 4'h0;
            wHeld_q  <= 1'h0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'h1;
                awAddr_q <= awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'h0;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'h1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'h0;
            end
        end
    end

    // writable registers live in byte lane 0
    always_ff @(posedge clock) begin
        if (reset) begin
            portsEnable_q <= `CONTROL_RESET;
            mask_q        <= `MASK_RESET;
        end else if (doWrite && wStrb_q[0]) begin
            if (awAddr_q == `REG_CONTROL) begin
                portsEnable_q <= wData_q[`CTRL_PORTS_ENABLE];
            end
            if (awAddr_q == `REG_MASK) begin
                mask_q <= wData_q[3:0];
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clock) begin
        if (reset) begin
            bvalid_q <= 1'h0;
            bresp_q  <= `RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'h1;
            bresp_q  <= isMapped(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'h0;
        end
    end

    always_comb begin
        stateWord = 32'h0000_0000;
        stateWord[`ST_OFFSET_LSB +: 7] = offsetValue_q;
        stateWord[`ST_SELECT_LSB +: 2] = offsetSel_q;
        stateWord[`ST_APPLIED_BIT]     = ~deviceResetN;
        stateWord[`ST_EVER_BIT]        = everReset_q;
        stateWord[`ST_COUNT0_LSB +: 7] = queueCount[0];
        stateWord[`ST_COUNT1_LSB +: 7] = queueCount[1];
    end

    // read data registered; unmapped words answer zero with an error
    always_ff @(posedge clock) begin
        if (reset) begin
            rvalid_q <= 1'h0;
            rresp_q  <= `RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'h1;
            rresp_q  <= isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (araddr)
                `REG_CONTROL: rdata_q <= {31'h0, portsEnable_q};
                `REG_STATUS:  rdata_q <= {28'h0, status_q};
                `REG_MASK:    rdata_q <= {28'h0, mask_q};
                `REG_STATE:   rdata_q <= stateWord;
                default:      rdata_q <= 32'h0000_0000;
            endcase
        end else if (rready) begin
            rvalid_q <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_short_pulse_keeps: assert property ((!deviceResetN && !countsFull) |=>
        (wrPtr_q[0] == $past(wrPtr_q[0]))) else $error("pointer moved before qualified reset");
    a_pointers_cleared: assert property ((!deviceResetN && countsFull) |=>
        (queueCount[0] == 7'h00 && rdPtr_q[1] == 7'h00)) else $error("pointers not cleared");
    a_flags_forced: assert property (!deviceResetN |=> (fullN_q == 2'h0 && emptyN_q == 2'h0 &&
        almostEmptyN_q == 2'h0 && almostFullN_q == 2'h3)) else $error("flags not forced");
    a_mail_flags_high: assert property (!deviceResetN |=> (mailOneFlagN && mailTwoFlagN))
        else $error("mailbox flags not high");
    a_full_waits_edges: assert property ((fullState_q[0] == dual_fifo_reset_and_offset_pkg::FULL_WAIT_FIRST)
        |-> !portAFullFlagN) else $error("port A full flag rose too early");
    a_full_rise_cause: assert property ($rose(portBFullFlagN) |-> ($past(clkRise[1]) &&
        $past(fullState_q[1]) == dual_fifo_reset_and_offset_pkg::FULL_WAIT_SECOND) ||
        $past(fullState_q[1]) == dual_fifo_reset_and_offset_pkg::FULL_OPEN)
        else $error("port B full flag rose without second edge");
    a_offset_latched: assert property (resetRelease |=>
        offsetSel_q == $past({offsetSelectHi, offsetSelectLo})) else $error("select not latched");
    a_offset_encoding: assert property (offsetValue_q == 7'(7'h04 + {offsetSel_q, 2'h0}))
        else $error("offset value does not match select code");
    a_write_ignored: assert property ((!portAFullFlagN && deviceResetN) |=>
        $stable(wrPtr_q[0])) else $error("write taken while full");
    a_read_ignored: assert property ((!portBEmptyFlagN && deviceResetN) |=>
        $stable(rdPtr_q[0])) else $error("read taken while empty");
    a_offset_stable: assert property ((deviceResetN && resetNPrev_q) |=>
        $stable(offsetValue_q)) else $error("offset changed outside reset release");

    c_reset_effect:  cover property (takingEffect);
    c_full_release:  cover property ($rose(portAFullFlagN) ##[1:200] $rose(portBFullFlagN));
    c_write_refused: cover property (|wrRefused);
    c_irq_raised:    cover property ($rose(interrupt));

endmodule : dual_fifo_reset_and_offset

// ### port_side_model.sv
// far-side model: the two controlling buses that clock ports a and b
`timescale 1ns/100ps
module port_side_model #(
    parameter int HALF_A = 2, // port a half period in system cycles
    parameter int HALF_B = 3  // port b half period, unrelated ratio to a
) (
    input  wire logic clock,
    input  wire logic reset,
    output logic      portAClock = 1'b0,
    output logic      portBClock = 1'b0
);
    int cntA = 0; // position within a half period of port a
    int cntB = 0; // same for port b
    // clocks keep running through a device reset so it sees enough edges
    always @(posedge clock) begin
        cntA <= (reset || cntA == HALF_A - 1) ? 0 : cntA + 1;
        cntB <= (reset || cntB == HALF_B - 1) ? 0 : cntB + 1;
        if (cntA == HALF_A - 1) portAClock <= ~portAClock;
        if (cntB == HALF_B - 1) portBClock <= ~portBClock;
    end
endmodule : port_side_model

// ### test_dual_fifo_reset_and_offset.sv
// self-checking bench for the reset and offset block
`timescale 1ns/100ps
`include "dual_fifo_reset_and_offset_defines.svh"
module test_dual_fifo_reset_and_offset;
    logic clock = 0, reset = 1, deviceResetN = 1, selLo = 0, selHi = 0, aWr = 0, bRd = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, portAClock, portBClock;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, interrupt;
    logic [1:0] bresp, rresp;
    logic [9:0] flags; // full a b, empty a b, almost empty a b, almost full a b, mail one two
    logic [33:0] expQ[$], maskQ[$]; // expected read answers, oldest first
    int errors = 0, checkCount = 0, cyc = 0;
    int vals[4] = '{4, 8, 12, 16};
    dual_fifo_reset_and_offset dut_u (.clock(clock), .reset(reset), .portAClock(portAClock),
        .portBClock(portBClock), .deviceResetN(deviceResetN), .offsetSelectLo(selLo),
        .offsetSelectHi(selHi), .portAWriteEnable(aWr), .portAReadEnable(bRd),
        .portBWriteEnable(aWr), .portBReadEnable(bRd), .portAFullFlagN(flags[9]),
        .portBFullFlagN(flags[8]), .portAEmptyFlagN(flags[7]), .portBEmptyFlagN(flags[6]),
        .portAAlmostEmptyFlagN(flags[5]), .portBAlmostEmptyFlagN(flags[4]),
        .portAAlmostFullFlagN(flags[3]), .portBAlmostFullFlagN(flags[2]),
        .mailOneFlagN(flags[1]), .mailTwoFlagN(flags[0]), .interrupt(interrupt),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    port_side_model far_u (.clock(clock), .reset(reset), .portAClock(portAClock),
        .portBClock(portBClock));
    initial forever #12.5 clock = ~clock;
    task conclude;
        if (errors == 0 && checkCount > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task compare(input logic [33:0] got, input logic [33:0] exp);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : compare
    // write: address and data offered together, each dropped once taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1; pw = 1;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (pa || pw) begin
            @(posedge clock);
            if (pa && awready) begin pa = 0; awvalid <= 0; end
            if (pw && wready) begin pw = 0; wvalid <= 0; end
        end
        do @(posedge clock); while (!bvalid);
        compare(34'(bresp), 34'(`RESP_OKAY));
        bready <= 0;
    endtask : wr
    // read: the answer is noted now and judged by the watcher below
    task rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
        expQ.push_back(e); maskQ.push_back(m);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clock); while (!arready);
        arvalid <= 0;
        do @(posedge clock); while (!rvalid);
    endtask : rd
    always @(posedge clock) if (rvalid && rready) compare({rresp, rdata} & maskQ.pop_front(), expQ.pop_front());
    // hang guard
    always @(posedge clock) if (++cyc == 20000) begin errors++; conclude; end
    initial begin
        void'($urandom(68536));
        repeat (8) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            repeat ($urandom_range(3)) @(posedge clock);
            deviceResetN <= 0; {selHi, selLo} <= 2'(i);
            repeat (30) @(posedge clock);
            compare(34'(flags), 34'h00F);
            deviceResetN <= 1;
            repeat (2) @(posedge clock);
            {selHi, selLo} <= 2'($urandom); // late pin change must not reach the offset
            compare(34'(flags[9:8]), 34'h0);
            repeat (20) @(posedge clock);
            compare(34'(flags[9:8]), 34'h3);
            rd(`REG_STATE, 34'(i * 256 + vals[i] + 'h2000), 34'h37F7F337F);
        end
        wr(`REG_MASK, 32'h3);
        compare(34'(interrupt), 34'h1);
        rd(`REG_STATUS, 34'h3, 34'h30000000F);
        @(posedge clock);
        compare(34'(interrupt), 34'h0);
        wr(`REG_MASK, 32'hC);
        bRd <= 1; repeat (20) @(posedge clock); bRd <= 0;
        compare(34'(interrupt), 34'h1);
        aWr <= 1; repeat (300) @(posedge clock); aWr <= 0;
        repeat (4) @(posedge clock);
        compare(34'(flags[9:2]), 34'h7C);
        rd(`REG_STATE, 34'h032402310, 34'h37F7F337F);
        rd(`REG_STATUS, 34'hC, 34'h30000000F);
        rd(4'h6, {`RESP_SLVERR, 32'h0}, 34'h3FFFFFFFF);
        conclude;
    end
endmodule : test_dual_fifo_reset_and_offset
